// ---- rtl/psr_defs.svh ----
/*
 * timing constants for the pseudo-static ram host controller.
 * assumes a 50 MHz system clock (20 ns period).
 */
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_CLK_PERIOD_PS     20000
// cycle times of the memory, in ps
`define PSR_T_CYCLE_PS        70000
`define PSR_T_ACCESS_PS       70000
`define PSR_T_PULSE_PS        60000
`define PSR_T_DATA_SETUP_PS   30000
`define PSR_T_FLOAT_PS        30000
`define PSR_T_GAP_PS          5000
`define PSR_T_SEL_MAX_PS      15000000
// derived cycle counts: access rounds up, pulse and gap take one cycle past the floor, longest rounds down
`define PSR_ACCESS_CYC  ((`PSR_T_ACCESS_PS + `PSR_CLK_PERIOD_PS - 1) / `PSR_CLK_PERIOD_PS)
`define PSR_PULSE_CYC   ((`PSR_T_FLOAT_PS + `PSR_T_DATA_SETUP_PS + `PSR_CLK_PERIOD_PS) / `PSR_CLK_PERIOD_PS)
`define PSR_GAP_CYC     ((`PSR_T_GAP_PS + `PSR_CLK_PERIOD_PS) / `PSR_CLK_PERIOD_PS)
`define PSR_SEL_MAX_CYC (`PSR_T_SEL_MAX_PS / `PSR_CLK_PERIOD_PS)
`define PSR_ADDR_W      20
`define PSR_DATA_W      16

`endif

// ---- rtl/psr_pkg.sv ----
/*
 * types for the pseudo-static ram host controller.
 * assumes psr_defs.svh is on the include path.
 */
`include "psr_defs.svh"
package psr_pkg;
   typedef enum logic [2:0] {
      PSR_IDLE,
      PSR_RD,
      PSR_WR_SETUP,
      PSR_WR_PULSE,
      PSR_WR_END,
      PSR_GAP
   } psr_state_t;

   // request from the user side
   typedef struct packed {
      logic                    write;
      logic [`PSR_ADDR_W-1:0]  addr;
      logic [`PSR_DATA_W-1:0]  wdata;
      logic [1:0]              byte_en;
   } psr_req_t;

   // memory pin outputs
   typedef struct packed {
      logic                    chip_select_low;
      logic                    chip_select_high_active;
      logic                    write_strobe_n;
      logic                    output_drive_n;
      logic                    upper_byte_sel_n;
      logic                    lower_byte_sel_n;
      logic [`PSR_ADDR_W-1:0]  addr;
      logic [`PSR_DATA_W-1:0]  dq_out;
      logic                    dq_oe;
   } psr_pins_t;

   typedef struct packed {
      psr_state_t              state;
      logic [9:0]              cnt;
      logic                    write;
      logic [`PSR_DATA_W-1:0]  rdata;
      logic                    rvalid;
      psr_pins_t               pins;
   } psr_regs_t;
endpackage

// ---- rtl/psr_host.sv ----
/*
 * host controller driving an asynchronous 1M x 16 pseudo-static ram.
 * one access per request; chip is deselected between accesses so the
 * memory can run its hidden refresh. assumes requests from clk_sys logic.
 */
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_host (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    req_valid,
   output      logic                    req_ready,
   input  wire psr_pkg::psr_req_t       req,
   output      logic                    rd_valid,
   output      logic [`PSR_DATA_W-1:0]  rd_data,
   output      psr_pkg::psr_pins_t      pins,
   input  wire logic [`PSR_DATA_W-1:0]  dq_in
);
   localparam logic [9:0] ACC_C  = 10'(`PSR_ACCESS_CYC);
   localparam logic [9:0] PUL_C  = 10'(`PSR_PULSE_CYC);
   localparam logic [9:0] GAP_C  = 10'(`PSR_GAP_CYC);
   localparam int         SEL_MX = `PSR_SEL_MAX_CYC;

   // ----------------------------------------------------------------
   // input synchroniser for the data pins
   // ----------------------------------------------------------------
   logic [`PSR_DATA_W-1:0] dq_meta;
   logic [`PSR_DATA_W-1:0] dq_sync;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dq_meta <= '0;
         dq_sync <= '0;
      end else begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   psr_pkg::psr_regs_t r;
   psr_pkg::psr_regs_t next_r;
   psr_pkg::psr_pins_t idle_pins;

   always_comb begin
      idle_pins = '0;
      idle_pins.chip_select_low  = 1'b1;
      idle_pins.write_strobe_n   = 1'b1;
      idle_pins.output_drive_n   = 1'b1;
      idle_pins.upper_byte_sel_n = 1'b1;
      idle_pins.lower_byte_sel_n = 1'b1;
   end

   always_comb begin
      next_r        = r;
      next_r.rvalid = 1'b0;
      unique case (r.state)
         psr_pkg::PSR_IDLE: begin
            if (req_valid) begin
               // address and byte selects set together with the select
               next_r.pins.addr                    = req.addr;
               next_r.pins.chip_select_low         = 1'b0;
               next_r.pins.chip_select_high_active = 1'b1;
               next_r.pins.upper_byte_sel_n        = ~req.byte_en[1];
               next_r.pins.lower_byte_sel_n        = ~req.byte_en[0];
               next_r.write = req.write;
               next_r.cnt   = 10'h001;
               if (req.write) begin
                  next_r.pins.output_drive_n = 1'b1;
                  next_r.pins.dq_out         = req.wdata;
                  next_r.pins.dq_oe          = 1'b1;
                  next_r.state               = psr_pkg::PSR_WR_SETUP;
               end else begin
                  next_r.pins.output_drive_n = 1'b0;
                  next_r.state               = psr_pkg::PSR_RD;
               end
            end
         end
         psr_pkg::PSR_RD: begin
            if (r.cnt >= ACC_C + 10'h002) begin
               // two extra cycles cover the pin synchroniser
               next_r.rdata  = dq_sync;
               next_r.rvalid = 1'b1;
               next_r.pins   = idle_pins;
               next_r.pins.addr = r.pins.addr;
               next_r.cnt    = 10'h001;
               next_r.state  = psr_pkg::PSR_GAP;
            end else begin
               next_r.cnt = r.cnt + 10'h001;
            end
         end
         psr_pkg::PSR_WR_SETUP: begin
            // write begins once the strobe joins the selects
            next_r.pins.write_strobe_n = 1'b0;
            next_r.cnt   = 10'h001;
            next_r.state = psr_pkg::PSR_WR_PULSE;
         end
         psr_pkg::PSR_WR_PULSE: begin
            if (r.cnt >= PUL_C) begin
               next_r.pins.write_strobe_n = 1'b1;
               next_r.state = psr_pkg::PSR_WR_END;
            end else begin
               next_r.cnt = r.cnt + 10'h001;
            end
         end
         psr_pkg::PSR_WR_END: begin
            // data and address held one cycle past the strobe edge
            next_r.pins      = idle_pins;
            next_r.pins.addr = r.pins.addr;
            next_r.cnt       = 10'h001;
            next_r.state     = psr_pkg::PSR_GAP;
         end
         psr_pkg::PSR_GAP: begin
            if (r.cnt >= GAP_C) begin
               next_r.state = psr_pkg::PSR_IDLE;
            end else begin
               next_r.cnt = r.cnt + 10'h001;
            end
         end
         default: next_r.state = psr_pkg::PSR_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         r                              <= '0;
         r.state                        <= psr_pkg::PSR_IDLE;
         r.pins.chip_select_low         <= 1'b1;
         r.pins.write_strobe_n          <= 1'b1;
         r.pins.output_drive_n          <= 1'b1;
         r.pins.upper_byte_sel_n        <= 1'b1;
         r.pins.lower_byte_sel_n        <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign req_ready = (r.state == psr_pkg::PSR_IDLE);
   assign rd_valid  = r.rvalid;
   assign rd_data   = r.rdata;
   assign pins      = r.pins;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic sel;
   logic [19:0] sel_cnt;
   assign sel = ~r.pins.chip_select_low & r.pins.chip_select_high_active;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) sel_cnt <= '0;
      else sel_cnt <= sel ? sel_cnt + 20'h00001 : '0;
   end

   property p_sel_window;
      @(posedge clk_sys) disable iff (!rst_b) sel |-> (int'(sel_cnt) < SEL_MX);
   endproperty
   a_sel_window: assert property (p_sel_window) else $error("select too long");

   property p_addr_stable;
      @(posedge clk_sys) disable iff (!rst_b) sel && $past(sel) |-> $stable(r.pins.addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("addr moved");

   property p_gap;
      @(posedge clk_sys) disable iff (!rst_b) $fell(sel) |-> !sel [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("deselect gap short");

   sequence s_strobe_low;
      !r.pins.write_strobe_n [*4];
   endsequence
   property p_pulse;
      @(posedge clk_sys) disable iff (!rst_b) $fell(r.pins.write_strobe_n) |-> s_strobe_low;
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse short");

   property p_wr_oe;
      @(posedge clk_sys) disable iff (!rst_b) !r.pins.write_strobe_n |-> r.pins.output_drive_n;
   endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("output drive in write");

   property p_hold;
      @(posedge clk_sys) disable iff (!rst_b)
         $rose(r.pins.write_strobe_n) |-> sel && r.pins.dq_oe && $stable(r.pins.dq_out);
   endproperty
   a_hold: assert property (p_hold) else $error("data not held");

   property p_strobe_in_sel;
      @(posedge clk_sys) disable iff (!rst_b) !r.pins.write_strobe_n |-> sel;
   endproperty
   a_strobe_in_sel: assert property (p_strobe_in_sel) else $error("strobe outside select");

   property p_read_once;
      @(posedge clk_sys) disable iff (!rst_b) r.rvalid |-> !sel ##1 !sel;
   endproperty
   a_read_once: assert property (p_read_once) else $error("reads chained");

   // ----------------------------------------------------------------
   // transfer walks
   // ----------------------------------------------------------------
   sequence s_rd_take;
      req_valid && req_ready && !req.write;
   endsequence
   sequence s_rd_open;
      (sel && !r.pins.output_drive_n && r.pins.write_strobe_n) [*6];
   endsequence
   sequence s_rd_close;
      !sel && r.rvalid && r.pins.output_drive_n;
   endsequence
   property p_rd_walk;
      @(posedge clk_sys) disable iff (!rst_b) s_rd_take |=> s_rd_open ##1 s_rd_close;
   endproperty
   a_rd_walk: assert property (p_rd_walk) else $error("read walk broken");

   sequence s_wr_take;
      req_valid && req_ready && req.write;
   endsequence
   sequence s_wr_setup;
      sel && r.pins.write_strobe_n && r.pins.dq_oe && r.pins.output_drive_n;
   endsequence
   sequence s_wr_pulse;
      (sel && !r.pins.write_strobe_n && r.pins.dq_oe) [*4];
   endsequence
   sequence s_wr_close;
      !sel && !r.pins.dq_oe && r.pins.write_strobe_n;
   endsequence
   property p_wr_walk;
      @(posedge clk_sys) disable iff (!rst_b)
         s_wr_take |=> s_wr_setup ##1 s_wr_pulse ##1 s_wr_setup ##1 s_wr_close;
   endproperty
   a_wr_walk: assert property (p_wr_walk) else $error("write walk broken");

   property p_ready_gap;
      @(posedge clk_sys) disable iff (!rst_b) $fell(sel) |-> !req_ready ##1 req_ready;
   endproperty
   a_ready_gap: assert property (p_ready_gap) else $error("ready early");

   property p_ready_idle;
      @(posedge clk_sys) disable iff (!rst_b)
         req_ready |-> !sel && r.pins.write_strobe_n && !r.pins.dq_oe;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");

   property p_sel_pair;
      @(posedge clk_sys) disable iff (!rst_b)
         r.pins.chip_select_low == !r.pins.chip_select_high_active;
   endproperty
   a_sel_pair: assert property (p_sel_pair) else $error("selects split");

   property p_lanes_stable;
      @(posedge clk_sys) disable iff (!rst_b)
         sel && $past(sel) |-> $stable({r.pins.upper_byte_sel_n, r.pins.lower_byte_sel_n})
            && $stable(r.pins.output_drive_n);
   endproperty
   a_lanes_stable: assert property (p_lanes_stable) else $error("lanes moved");

   property p_data_stable;
      @(posedge clk_sys) disable iff (!rst_b) !r.pins.write_strobe_n |-> $stable(r.pins.dq_out);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved");

   property p_strobe_setup;
      @(posedge clk_sys) disable iff (!rst_b)
         $fell(r.pins.write_strobe_n) |-> $past(sel) && $past(r.pins.dq_oe);
   endproperty
   a_strobe_setup: assert property (p_strobe_setup) else $error("strobe early");

   // select drops only after the strobe has ended the write
   property p_strobe_first;
      @(posedge clk_sys) disable iff (!rst_b) $fell(sel) |-> $past(r.pins.write_strobe_n);
   endproperty
   a_strobe_first: assert property (p_strobe_first) else $error("select cut");

   property p_addr_after;
      @(posedge clk_sys) disable iff (!rst_b) $fell(sel) |-> $stable(r.pins.addr);
   endproperty
   a_addr_after: assert property (p_addr_after) else $error("addr dropped");

   property p_oe_write;
      @(posedge clk_sys) disable iff (!rst_b) r.pins.dq_oe |-> sel && r.pins.output_drive_n;
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("bus fight");

   property p_rd_drive;
      @(posedge clk_sys) disable iff (!rst_b)
         !r.pins.output_drive_n |-> sel && r.pins.write_strobe_n && !r.pins.dq_oe;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("drive in write");

   property p_rvalid_pulse;
      @(posedge clk_sys) disable iff (!rst_b) r.rvalid |=> !r.rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("valid too long");

   property p_reselect;
      @(posedge clk_sys) disable iff (!rst_b) $rose(sel) |-> !$past(sel, 2);
   endproperty
   a_reselect: assert property (p_reselect) else $error("reselect early");
endmodule

// ---- tb/psr_mem_model.sv ----
/* behavioural pseudo-static ram seen through the host's pin struct.
   assumes clk_sys only to make the floating bus pattern and to latch the bus clash flag. */
`timescale 1ns/1ps
module psr_mem_model (
   input  wire logic               clk_sys,
   input  wire psr_pkg::psr_pins_t pins,
   output      logic [15:0]        dq
);
   logic [15:0] mem [0:255];
   logic [15:0] last;
   logic        sel, wr, rd, lost, clash;
   realtime     t_sel, t_des;
   assign sel = !pins.chip_select_low && pins.chip_select_high_active;
   assign wr = sel && !pins.write_strobe_n
               && !(pins.upper_byte_sel_n && pins.lower_byte_sel_n);
   assign rd = sel && !pins.output_drive_n && pins.write_strobe_n;
   initial begin
      lost = 1'b0;
      clash = 1'b0;
      last = 16'h0;
      t_des = 0.0;
      foreach (mem[i]) mem[i] = 16'h0;
   end
   // released bus shows the inverse of its last level
   always @* begin
      dq = ~last;
      if (pins.dq_oe)
         dq = pins.dq_out;
      else if (rd) begin
         if (!pins.upper_byte_sel_n) dq[15:8] = mem[pins.addr[7:0]][15:8];
         if (!pins.lower_byte_sel_n) dq[7:0] = mem[pins.addr[7:0]][7:0];
      end
   end
   always @* begin
      if (wr && !pins.upper_byte_sel_n) mem[pins.addr[7:0]][15:8] = dq[15:8];
      if (wr && !pins.lower_byte_sel_n) mem[pins.addr[7:0]][7:0] = dq[7:0];
   end
   // refresh only when deselected long enough; long select loses contents
   always @(sel) begin
      if (sel) begin
         t_sel = $realtime;
         if ($realtime - t_des <= 5.0 && $realtime > 0.0) lost = 1'b1;
      end else begin
         t_des = $realtime;
         if ($realtime - t_sel > 15000.0) lost = 1'b1;
      end
   end
   always @(posedge clk_sys) begin
      last <= dq;
      if (pins.dq_oe && rd) clash <= 1'b1;
   end
endmodule

// ---- tb/psr_host_tb_top.sv ----
/* self-checking bench for psr_host against the ram model.
   assumes psr_defs.svh on the include path and a 50 MHz clock. */
`timescale 1ns/1ps
module psr_host_tb_top;
   logic               clk_sys, rst_b, req_valid, req_ready, rd_valid;
   logic [15:0]        rd_data, dq_in;
   psr_pkg::psr_req_t  req;
   psr_pkg::psr_pins_t pins;
   int                 fail_count, num_checks, cycles;
   psr_host psr_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
      .pins(pins), .dq_in(dq_in));
   psr_mem_model psr_mem_model_inst (.clk_sys(clk_sys), .pins(pins), .dq(dq_in));
   always #10 clk_sys = ~clk_sys;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one access, walked and judged for ten cycles after it is taken
   task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                         input logic [1:0] be);
      int          sel_n, stb_n, first, rv_at, bus_bad, a_bad;
      logic [15:0] got;
      sel_n = 0;
      stb_n = 0;
      first = -1;
      rv_at = -1;
      bus_bad = 0;
      a_bad = 0;
      req_valid = 1'b1;
      req = '{write: wr, addr: a, wdata: d, byte_en: be};
      while (req_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      req_valid = 1'b0;
      for (int k = 0; k < 10; k++) begin
         if (!pins.chip_select_low && pins.chip_select_high_active) begin
            sel_n++;
            if (first < 0) first = k;
            if (pins.addr !== a || {pins.upper_byte_sel_n, pins.lower_byte_sel_n} !== ~be)
               a_bad++;
            if (wr && (!pins.output_drive_n || !pins.dq_oe || pins.dq_out !== d)) bus_bad++;
         end
         if (!pins.write_strobe_n) stb_n++;
         if (rd_valid === 1'b1) begin
            rv_at = k;
            got = rd_data;
         end
         @(negedge clk_sys);
      end
      check("selected cycles", sel_n, 6);
      check("strobe cycles", stb_n, wr ? 4 : 0);
      check("address lanes", a_bad, 0);
      check("write bus", bus_bad, 0);
      if (!wr) begin
         check("read valid cycle", rv_at - first, 6);
         check("read data", got, d);
      end
   endtask
   task automatic t_reset();
      check("idle pins", {pins.chip_select_low, pins.chip_select_high_active,
         pins.write_strobe_n, pins.output_drive_n, pins.upper_byte_sel_n,
         pins.lower_byte_sel_n, pins.dq_oe}, 7'h5e);
      check("idle ready", {req_ready, rd_valid}, 2'h2);
      $display("test reset done");
   endtask
   task automatic t_rw();
      access(1'b1, 20'h00011, 16'h1234, 2'h3);
      access(1'b1, 20'h00012, 16'hfedc, 2'h3);
      access(1'b0, 20'h00011, 16'h1234, 2'h3);
      access(1'b0, 20'h00012, 16'hfedc, 2'h3);
      $display("test write read done");
   endtask
   task automatic t_lanes();
      access(1'b1, 20'h00011, 16'habcd, 2'h2);
      access(1'b1, 20'h00012, 16'h5a5a, 2'h1);
      access(1'b0, 20'h00011, 16'hab34, 2'h3);
      access(1'b0, 20'h00012, 16'hfe5a, 2'h3);
      $display("test byte lanes done");
   endtask
   task automatic t_abort();
      req_valid = 1'b1;
      req = '{write: 1'b1, addr: 20'h00013, wdata: 16'h0f0f, byte_en: 2'h3};
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b0;
      req_valid = 1'b0;
      #1;
      t_reset();
      @(negedge clk_sys);
      rst_b = 1'b1;
      access(1'b0, 20'h00011, 16'hab34, 2'h3);
      check("model lost data", psr_mem_model_inst.lost, 1'b0);
      check("bus clash", psr_mem_model_inst.clash, 1'b0);
      $display("test abort done");
   endtask
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      fail_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (3) @(negedge clk_sys);
      t_reset();
      rst_b = 1'b1;
      t_rw();
      t_lanes();
      t_abort();
      final_report();
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 2000) begin
         fail_count++;
         final_report();
      end
   end
endmodule
